// >>> design/gecr_pkg.sv
// Purpose: Shared constants for the gauge emulation and command register bank
// Assumes: 16-bit register addresses and 32-bit register data on the host port
// Notes: Command registers are one bit wide and read back as zero

package gecr_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CMD_N = 6;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [15:0] EMUL_CTRL_ADDR = 16'h7fe2;
  localparam logic [15:0] PREV_ITER_ADDR = 16'h7fe3;
  localparam logic [15:0] SLEEP_CMD_ADDR = 16'h7ff0;
  localparam logic [15:0] PROTECT_CMD_ADDR = 16'h7ff1;
  localparam logic [15:0] DEFAULTS_CMD_ADDR = 16'h7ff2;
  localparam logic [15:0] RESTART_CMD_ADDR = 16'h7ff3;
  localparam logic [15:0] CC_TOGGLE_CMD_ADDR = 16'h7ff4;
  localparam logic [15:0] CC_CLEAR_CMD_ADDR = 16'h7ff5;

  // ****************************************************************
  // Command slots, index into the command pulse bank
  // ****************************************************************
  localparam int CMD_SLEEP = 0;
  localparam int CMD_PROTECT = 1;
  localparam int CMD_DEFAULTS = 2;
  localparam int CMD_RESTART = 3;
  localparam int CMD_CC_TOGGLE = 4;
  localparam int CMD_CC_CLEAR = 5;

  // Offset of each command slot
  localparam logic [15:0] CMD_ADDR [CMD_N] = '{
    SLEEP_CMD_ADDR, PROTECT_CMD_ADDR, DEFAULTS_CMD_ADDR,
    RESTART_CMD_ADDR, CC_TOGGLE_CMD_ADDR, CC_CLEAR_CMD_ADDR
  };

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int EMUL_ON_BIT = 0;
  localparam int ITER_RUN_BIT = 1;
  localparam int ITER_DONE_BIT = 2;
  localparam int FETCH_BUSY_BIT = 3;
  localparam int FIRST_PEND_BIT = 4;
  localparam logic [7:0] CMD_GO = 8'h01;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : gecr_pkg

// >>> design/gecr_cmd_pulse.sv
// Purpose: One self-clearing command register turned into an action pulse
// Assumes: Write strobe and data come from logic on the same clock
// Notes: Only the value 0x01 triggers; the stored value never reads back

`timescale 1ns/100ps

module gecr_cmd_pulse
  import gecr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_hit_i,
  input wire logic [BYTE_W-1:0] wdata_i,
  output logic pulse_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Accept only the go value, anything else is ignored
  wire logic go_w = wr_hit_i && (wdata_i == CMD_GO);

  // ****************************************************************
  // Command register
  // ****************************************************************
  // Holds for one cycle then falls back to zero on its own
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= go_w;
    end
  end

endmodule : gecr_cmd_pulse

// >>> design/gecr_regs.sv
// Purpose: Emulated gauge status bits and self-clearing command registers
// Assumes: Register port driven by the serial protocol engine on clk_i
// Notes: Gauge-side handshakes arrive as same-clock levels and pulses

`timescale 1ns/100ps

module gecr_regs
  import gecr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic gauge_output_fetch_i,
  input wire logic gauge_input_xfer_i,
  input wire logic gauge_iter_running_i,
  input wire logic gauge_iter_done_i,
  input wire logic gauge_iter_capture_i,
  input wire logic [DATA_W-1:0] gauge_iteration_counter_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic emulated_gauge_on_o,
  output logic gauge_output_fetch_busy_o,
  output logic first_input_pending_o,
  output logic sleep_entry_o,
  output logic protective_state_o,
  output logic restore_defaults_o,
  output logic unit_restart_cmd_o,
  output logic charge_counter_clear_cmd_o,
  output logic charge_counter_running_o
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Write and read hits per register
  wire logic wr_emul_w = reg_wr_i && (reg_addr_i == EMUL_CTRL_ADDR);
  wire logic rd_emul_w = reg_addr_i == EMUL_CTRL_ADDR;
  wire logic rd_iter_w = reg_addr_i == PREV_ITER_ADDR;
  wire logic [BYTE_W-1:0] wbyte_w = reg_wdata_i[BYTE_W-1:0];
  wire logic [CMD_N-1:0] cmd_pulse_w;

  // ****************************************************************
  // Command registers
  // ****************************************************************
  // One self-clearing register per command slot
  genvar gi;
  generate
    for (gi = 0; gi < CMD_N; gi = gi + 1) begin : g_cmd
      gecr_cmd_pulse u_cmd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_hit_i(reg_wr_i && (reg_addr_i == CMD_ADDR[gi])),
        .wdata_i(wbyte_w),
        .pulse_o(cmd_pulse_w[gi])
      );
    end
  endgenerate

  // Commands routed to the unit, each one clock wide
  assign sleep_entry_o = cmd_pulse_w[CMD_SLEEP];
  assign protective_state_o = cmd_pulse_w[CMD_PROTECT];
  assign restore_defaults_o = cmd_pulse_w[CMD_DEFAULTS];
  assign unit_restart_cmd_o = cmd_pulse_w[CMD_RESTART];
  assign charge_counter_clear_cmd_o = cmd_pulse_w[CMD_CC_CLEAR];

  // ****************************************************************
  // Emulation control
  // ****************************************************************
  // Restart and restore defaults both drop back to configuration default
  wire logic cfg_reset_w = cmd_pulse_w[CMD_RESTART] || cmd_pulse_w[CMD_DEFAULTS];
  wire logic emul_go_w = wr_emul_w && (wbyte_w == CMD_GO);
  logic emul_on_d;
  logic emul_on_q;

  // Any low byte but 0x01 turns emulation off
  always_comb begin
    emul_on_d = emul_on_q;
    if (cfg_reset_w) begin
      emul_on_d = 1'b0;
    end else if (wr_emul_w) begin
      emul_on_d = emul_go_w;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      emul_on_q <= 1'b0;
    end else begin
      emul_on_q <= emul_on_d;
    end
  end

  assign emulated_gauge_on_o = emul_on_q;

  // ****************************************************************
  // First-input-pending flag
  // ****************************************************************
  // Turn-on event: off now, on next cycle
  wire logic emul_rise_w = emul_on_d && !emul_on_q;
  logic first_pend_d;
  logic first_pend_q;

  // Set on turn-on beats the clear; off forces zero
  always_comb begin
    first_pend_d = first_pend_q;
    if (!emul_on_d) begin
      first_pend_d = 1'b0;
    end else if (emul_rise_w) begin
      first_pend_d = 1'b1;
    end else if (gauge_input_xfer_i) begin
      first_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_pend_q <= 1'b0;
    end else begin
      first_pend_q <= first_pend_d;
    end
  end

  assign first_input_pending_o = first_pend_q;

  // ****************************************************************
  // Output fetch busy flag
  // ****************************************************************
  // Follows the fetch in progress, zero while emulation is off
  logic fetch_busy_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_busy_q <= 1'b0;
    end else begin
      fetch_busy_q <= emul_on_d && gauge_output_fetch_i;
    end
  end

  assign gauge_output_fetch_busy_o = fetch_busy_q;

  // ****************************************************************
  // Previous iteration count
  // ****************************************************************
  // Captured when an iteration's counter is handed over
  logic [DATA_W-1:0] prev_iter_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_iter_q <= DATA_ZERO;
    end else if (gauge_iter_capture_i) begin
      prev_iter_q <= gauge_iteration_counter_i;
    end
  end

  // ****************************************************************
  // Charge counter run state
  // ****************************************************************
  // Toggle flips the run state; restart stops counting
  logic cc_run_d;
  logic cc_run_q;

  always_comb begin
    cc_run_d = cc_run_q;
    if (cmd_pulse_w[CMD_RESTART]) begin
      cc_run_d = 1'b0;
    end else if (cmd_pulse_w[CMD_CC_TOGGLE]) begin
      cc_run_d = !cc_run_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cc_run_q <= 1'b0;
    end else begin
      cc_run_q <= cc_run_d;
    end
  end

  assign charge_counter_running_o = cc_run_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Status word; iteration flags are gated by the enable as well
  logic [DATA_W-1:0] status_w;

  always_comb begin
    status_w = DATA_ZERO;
    status_w[EMUL_ON_BIT] = emul_on_q;
    status_w[ITER_RUN_BIT] = emul_on_q && gauge_iter_running_i;
    status_w[ITER_DONE_BIT] = emul_on_q && gauge_iter_done_i;
    status_w[FETCH_BUSY_BIT] = emul_on_q && fetch_busy_q;
    status_w[FIRST_PEND_BIT] = emul_on_q && first_pend_q;
  end

  // Command and unmapped offsets read as zero
  wire logic [DATA_W-1:0] rdata_w = rd_emul_w ? status_w :
                                    rd_iter_w ? prev_iter_q : DATA_ZERO;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= DATA_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_w : DATA_ZERO;
      reg_rvalid_o <= reg_rd_i;
    end
  end

endmodule : gecr_regs

// >>> testbench/gecr_host_model.sv
// Purpose: Host side register master for the gauge command bank
// Assumes: Strobes change at falling edges, one cycle each
// Notes: Idle address and data show the inverse of the last value

`timescale 1ns/100ps

module gecr_host_model
  import gecr_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);
  // Quiet port at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
  end

  // One write strobe, then stale fields are scrambled
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr

  // One read strobe, data taken while valid stands
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hdead_beef;
  endtask : rd
endmodule : gecr_host_model

// >>> testbench/gecr_checker.sv
// Purpose: Port level checks of the gauge command bank
// Assumes: One clock, asynchronous active high reset
// Notes: Attached to every instance by bind

`timescale 1ns/100ps

module gecr_checker
  import gecr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic gauge_output_fetch_i,
  input wire logic gauge_input_xfer_i,
  input wire logic reg_rvalid_o,
  input wire logic emulated_gauge_on_o,
  input wire logic gauge_output_fetch_busy_o,
  input wire logic first_input_pending_o,
  input wire logic sleep_entry_o,
  input wire logic protective_state_o,
  input wire logic restore_defaults_o,
  input wire logic unit_restart_cmd_o,
  input wire logic charge_counter_clear_cmd_o,
  input wire logic charge_counter_running_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write carrying the go value
  wire go_wr = reg_wr_i && (reg_wdata_i[7:0] == CMD_GO);
  wire kill = unit_restart_cmd_o || restore_defaults_o;
  // Toggle request not overridden by a restart
  sequence s_toggle;
    go_wr && reg_addr_i == CC_TOGGLE_CMD_ADDR ##1 !unit_restart_cmd_o;
  endsequence
  property p_cmd(a, p);
    go_wr && reg_addr_i == a |=> p;
  endproperty
  property p_cause(a, p);
    p |-> $past(go_wr) && $past(reg_addr_i) == a;
  endproperty
  a_cmd_sleep_go: assert property (p_cmd(SLEEP_CMD_ADDR, sleep_entry_o)) else $error("no sleep pulse");
  a_cmd_protect_go: assert property (p_cmd(PROTECT_CMD_ADDR, protective_state_o)) else $error("no safe pulse");
  a_cmd_defaults_go: assert property (p_cmd(DEFAULTS_CMD_ADDR, restore_defaults_o)) else $error("no defaults pulse");
  a_cmd_restart_go: assert property (p_cmd(RESTART_CMD_ADDR, unit_restart_cmd_o)) else $error("no restart pulse");
  a_cmd_clear_go: assert property (p_cmd(CC_CLEAR_CMD_ADDR, charge_counter_clear_cmd_o)) else $error("no clear pulse");
  a_sleep_self_clear: assert property (p_cause(SLEEP_CMD_ADDR, sleep_entry_o)) else $error("stray sleep pulse");
  a_clear_self_clear: assert property (p_cause(CC_CLEAR_CMD_ADDR, charge_counter_clear_cmd_o)) else $error("stray clear pulse");
  a_enable_go_on: assert property (go_wr && reg_addr_i == EMUL_CTRL_ADDR && !kill |=> emulated_gauge_on_o) else $error("not enabled");
  a_enable_other_off: assert property (reg_wr_i && !go_wr && reg_addr_i == EMUL_CTRL_ADDR |=> !emulated_gauge_on_o) else $error("not disabled");
  a_first_on_rise: assert property ($rose(emulated_gauge_on_o) |-> first_input_pending_o) else $error("first not set");
  a_xfer_clears_first: assert property (first_input_pending_o && gauge_input_xfer_i |=> !first_input_pending_o) else $error("first kept");
  a_fetch_busy_follow: assert property (gauge_output_fetch_busy_o == (emulated_gauge_on_o && $past(gauge_output_fetch_i))) else $error("busy wrong");
  a_status_gated_off: assert property (!emulated_gauge_on_o |-> !gauge_output_fetch_busy_o && !first_input_pending_o) else $error("status while off");
  a_toggle_flips: assert property (s_toggle |=> $changed(charge_counter_running_o)) else $error("no toggle");
  a_restart_stops_cc: assert property (unit_restart_cmd_o |=> !charge_counter_running_o) else $error("counter kept");
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
endmodule : gecr_checker

bind gecr_regs gecr_checker u_chk (.*);

// >>> testbench/testbench.sv
// Purpose: Self-checking bench of the gauge command bank
// Assumes: Stimulus at falling edges, checks where outputs are settled
// Notes: Host tasks live in the host model

`timescale 1ns/100ps

module testbench
  import gecr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i, reg_rd_i, gauge_output_fetch_i, gauge_input_xfer_i;
  logic gauge_iter_running_i, gauge_iter_done_i, gauge_iter_capture_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, gauge_iteration_counter_i, reg_rdata_o, rd_v;
  logic reg_rvalid_o, emulated_gauge_on_o, gauge_output_fetch_busy_o, first_input_pending_o;
  logic sleep_entry_o, protective_state_o, restore_defaults_o, unit_restart_cmd_o;
  logic charge_counter_clear_cmd_o, charge_counter_running_o;
  logic [CMD_N-1:0] pulses;
  int err_total = 0;
  int total_checks = 0;
  // Pulses in command slot order, toggle has no pulse port
  assign pulses = {charge_counter_clear_cmd_o, 1'b0, unit_restart_cmd_o,
    restore_defaults_o, protective_state_o, sleep_entry_o};
  always #10 clk_i = ~clk_i;
  gecr_regs uut (.*);
  gecr_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

  // Compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Reset values, unmapped address included
  task automatic t_reset;
    logic [ADDR_W-1:0] a [4] = '{EMUL_CTRL_ADDR, PREV_ITER_ADDR, CC_TOGGLE_CMD_ADDR, 16'h1234};
    foreach (a[i]) begin
      host.rd(a[i], rd_v);
      check(rd_v, DATA_ZERO);
    end
  endtask : t_reset

  // Each command but toggle: wrong value ignored, go value pulses once, reads zero
  task automatic t_cmds;
    for (int i = 0; i < CMD_N; i++) begin
      if (i != CMD_CC_TOGGLE) begin
        host.wr(CMD_ADDR[i], 32'h0000_0102);
        check(pulses[i], 1'b0);
        host.wr(CMD_ADDR[i], 32'h0000_0001);
        check(pulses[i], 1'b1);
        @(negedge clk_i);
        check(pulses[i], 1'b0);
        host.rd(CMD_ADDR[i], rd_v);
        check(rd_v, DATA_ZERO);
      end
    end
  endtask : t_cmds

  // Counter toggles on and off, restart stops it
  task automatic t_cc;
    for (int i = 0; i < 3; i++) begin
      host.wr(CC_TOGGLE_CMD_ADDR, 32'h0000_0001);
      @(negedge clk_i);
      check(charge_counter_running_o, (i == 1) ? 1'b0 : 1'b1);
    end
    host.wr(RESTART_CMD_ADDR, 32'h0000_0001);
    @(negedge clk_i);
    check(charge_counter_running_o, 1'b0);
  endtask : t_cc

  // Emulation on, fetch busy, first input, then off clears status
  task automatic t_emul;
    host.wr(EMUL_CTRL_ADDR, 32'h0000_0001);
    check(emulated_gauge_on_o, 1'b1);
    check(first_input_pending_o, 1'b1);
    gauge_output_fetch_i = 1'b1;
    gauge_iter_running_i = 1'b1;
    gauge_iter_done_i = 1'b1;
    host.rd(EMUL_CTRL_ADDR, rd_v);
    check(rd_v, 32'h0000_001f);
    gauge_iter_done_i = 1'b0;
    gauge_input_xfer_i = 1'b1;
    @(negedge clk_i);
    gauge_input_xfer_i = 1'b0;
    check(first_input_pending_o, 1'b0);
    host.wr(EMUL_CTRL_ADDR, 32'h0000_0001);
    check(first_input_pending_o, 1'b0);
    check(gauge_output_fetch_busy_o, 1'b1);
    host.wr(EMUL_CTRL_ADDR, 32'h0000_0003);
    check(emulated_gauge_on_o, 1'b0);
    host.rd(EMUL_CTRL_ADDR, rd_v);
    check(rd_v, DATA_ZERO);
    gauge_output_fetch_i = 1'b0;
    gauge_iter_running_i = 1'b0;
  endtask : t_emul

  // Captured iteration count reads back, writes ignored
  task automatic t_iter;
    gauge_iteration_counter_i = 32'ha5a5_1234;
    gauge_iter_capture_i = 1'b1;
    @(negedge clk_i);
    gauge_iter_capture_i = 1'b0;
    gauge_iteration_counter_i = 32'h0bad_0bad;
    host.wr(PREV_ITER_ADDR, 32'h0000_0000);
    host.rd(PREV_ITER_ADDR, rd_v);
    check(rd_v, 32'ha5a5_1234);
  endtask : t_iter

  // Main sequence
  initial begin
    gauge_output_fetch_i = 1'b0;
    gauge_input_xfer_i = 1'b0;
    gauge_iter_running_i = 1'b0;
    gauge_iter_done_i = 1'b0;
    gauge_iter_capture_i = 1'b0;
    gauge_iteration_counter_i = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_cmds();
    t_cc();
    t_emul();
    t_iter();
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule : testbench
